//--- core/filter_ctrl_if.sv
`timescale 1ns/1ps
interface filter_ctrl_if;
  import trig_cond_pkg::*;
  logic                    enable;
  logic [FILTER_LEN_W-1:0] length;
  logic                    level_in;
  logic                    level_out;
  modport ctrl
  (
    output enable,
    output length,
    output level_in,
    input  level_out
  );
  modport filt
  (
    input  enable,
    input  length,
    input  level_in,
    output level_out
  );
endinterface

//--- core/glitch_filter.sv
`timescale 1ns/1ps
module glitch_filter
  import trig_cond_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  filter_ctrl_if.filt fc
);
  // length counts 15 ns units; scaled to this 20 ns clock, rounded up
  function automatic logic [FILTER_LEN_W-1:0] to_cycles(input logic [FILTER_LEN_W-1:0] len);
    logic [FILTER_LEN_W+15:0] prod;
    prod = {16'h0000, len} * 36'(FILTER_UNIT_PS);
    return FILTER_LEN_W'((prod + 36'(CLK_PERIOD_PS - 1)) / 36'(CLK_PERIOD_PS));
  endfunction

  logic                    level_r;
  logic [FILTER_LEN_W-1:0] cnt_r;
  logic [FILTER_LEN_W-1:0] limit;

  assign limit = to_cycles(fc.length); // RL9

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      level_r <= 1'b0;
      cnt_r   <= '0;
    end
    else if (fc.level_in == level_r)
      cnt_r <= '0; // RL8
    else if (cnt_r + FILTER_LEN_W'(1) >= limit)
    begin
      level_r <= fc.level_in; // RL8
      cnt_r   <= '0;
    end
    else
      cnt_r <= cnt_r + FILTER_LEN_W'(1);
  end

  assign fc.level_out = fc.enable ? level_r : fc.level_in; // RL10
endmodule

//--- core/trig_cond_pkg.sv
package trig_cond_pkg;
  // combiner operations
  typedef enum logic [2:0] {
    OP_AND,
    OP_NAND,
    OP_OR,
    OP_NOR,
    OP_NOR_INV
  } comb_op_t;

  localparam int unsigned CLK_PERIOD_PS       = 20000;
  localparam int unsigned FILTER_UNIT_PS      = 15000;
  localparam int unsigned FILTER_LEN_W        = 20;
  localparam int unsigned FILTER_LEN_1MS      = 66666;
  localparam int unsigned SYNC_STAGES         = 2;
  localparam int unsigned PRESCALE_W          = 4;
  localparam int unsigned NUM_IN              = 4;
  localparam int unsigned NUM_STAGES          = 2;
  localparam int unsigned SEL_W               = 3;
  localparam int unsigned NUM_OUT             = 2;
  localparam logic [2:0]  SEL_RESET           = 3'h0;
endpackage

//--- core/trigger_input_conditioner.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: AND mode output high only while both selected inputs are high.
// RL2: NAND mode output is the inverse of AND.
// RL3: OR mode output low only when neither input is high.
// RL4: NOR mode inverts both inputs then ANDs: high only when both low.
// RL5: inverted-NOR gives low only when both inputs low.
// RL6: each stage takes exactly two sources: input lines or other stage outputs; the code lets a stage take earlier stages only.
// RL7: a stage result can drive the camera trigger, a later stage or an output line.
// RL8: debouncer passes a level only after it held the programmed length.
// RL9: filter length counts 15 ns units; 66666 is about one millisecond.
// RL10: debouncer enabled sits between selected line and trigger; disabled bypasses.
// RL11: prescaler divisor is a 4-bit setting, sixteen settings, up to divide by 16.
// RL12: prescaler forwards one pulse per divisor pulses and drops the rest.
// RL13: prescaler counts rising edges, pulses at divisor, restarts; divisor change clears.
// RL14: everything runs on clk; inputs pass a two-stage synchroniser first.
module trigger_input_conditioner
  import trig_cond_pkg::*;
#(
  parameter int unsigned NIN  = NUM_IN,
  parameter int unsigned NSTG = NUM_STAGES,
  parameter int unsigned NOUT = NUM_OUT
)
(
  input  wire logic                                   clk,
  input  wire logic                                   reset_n,
  input  wire logic [NIN-1:0]                         trig_in,
  input  wire logic [NSTG-1:0][2:0]                   stage_op,
  input  wire logic [NSTG-1:0][SEL_W-1:0]             stage_sel_a,
  input  wire logic [NSTG-1:0][SEL_W-1:0]             stage_sel_b,
  input  wire logic [SEL_W-1:0]                       trig_sel,
  input  wire logic [NOUT-1:0][SEL_W-1:0]             out_sel,
  input  wire logic                                   filter_enable,
  input  wire logic [trig_cond_pkg::FILTER_LEN_W-1:0] glitch_filter_length,
  input  wire logic [trig_cond_pkg::PRESCALE_W-1:0]   prescale_div,
  output logic                                        camera_trigger,
  output logic [NOUT-1:0]                             out_line
);
  import trig_cond_pkg::*;

  // source space: input lines first, then stage results
  localparam int unsigned NSRC = NIN + NSTG;

  function automatic logic combine(input logic [2:0] op, input logic a, input logic b);
    logic y;
    y = 1'b0;
    unique case (comb_op_t'(op))
      OP_AND:     y = a & b; // RL1
      OP_NAND:    y = ~(a & b); // RL2
      OP_OR:      y = a | b; // RL3
      OP_NOR:     y = ~a & ~b; // RL4
      OP_NOR_INV: y = ~(~a & ~b); // RL5
      default:    y = 1'b0;
    endcase
    return y;
  endfunction

  // an index past the source space reads as low instead of wrapping onto a real line
  function automatic logic pick(input logic [NSRC-1:0] src, input logic [SEL_W-1:0] sel);
    return (32'(sel) < NSRC) ? src[sel] : 1'b0;
  endfunction

  // only sync2_r is read downstream; sync1_r may still be settling from a metastable sample
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync1_r <= '0;
    end
    else
    begin
      sync1_r <= trig_in; // RL14
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync2_r <= '0;
    end
    else
    begin
      sync2_r <= sync1_r; // RL14
    end
  end

  // stages may take earlier stages only; a later source reads as low, so no loop
  logic [NSTG-1:0] stage_a;
  logic [NSTG-1:0] stage_b;
  logic [NSTG-1:0] stage_y;
  logic [NSRC-1:0] src;

  always_comb
  begin
    src          = '0;
    src[NIN-1:0] = sync2_r;
    for (int s = 0; s < NSTG; s++)
    begin
      stage_a[s] = pick(src, stage_sel_a[s]); // RL6
      stage_b[s] = pick(src, stage_sel_b[s]); // RL6
      stage_y[s] = combine(stage_op[s], stage_a[s], stage_b[s]);
      src[NIN+s] = stage_y[s]; // RL7
    end
  end

  // registered so a line output never shows the glitches of the combiner chain
  logic [NOUT-1:0] out_nxt;

  always_comb
  begin
    for (int o = 0; o < NOUT; o++)
    begin
      out_nxt[o] = pick(src, out_sel[o]); // RL7
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      out_line <= '0;
    end
    else
    begin
      out_line <= out_nxt;
    end
  end

  // the filter runs even while bypassed, so enabling it never starts from a stale level
  logic           trig_level;
  filter_ctrl_if  fc ();

  assign trig_level  = pick(src, trig_sel); // RL7
  assign fc.enable   = filter_enable; // RL10
  assign fc.length   = glitch_filter_length; // RL9
  assign fc.level_in = trig_level;

  glitch_filter u_filter
  (
    .clk     (clk),
    .reset_n (reset_n),
    .fc      (fc.filt)
  );

  // prescaler: divisor value 0 means divide by 16, so all sixteen codes are usable
  logic                  level_d_r;
  logic [PRESCALE_W-1:0] div_r;
  logic [PRESCALE_W:0]   div_eff;
  logic [PRESCALE_W:0]   pcnt_r;
  logic [PRESCALE_W:0]   pcnt_inc;
  logic                  div_changed;
  logic                  rise;
  logic                  fire;

  assign div_eff     = (prescale_div == '0) ? (PRESCALE_W+1)'(16) : {1'b0, prescale_div}; // RL11
  assign div_changed = div_r != prescale_div;
  assign rise        = fc.level_out & ~level_d_r; // RL13
  assign pcnt_inc    = pcnt_r + (PRESCALE_W+1)'(1);
  // an edge in the cycle of a divisor change is lost with the old count
  assign fire        = rise & ~div_changed & (pcnt_inc >= div_eff); // RL12

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      level_d_r <= 1'b0;
    end
    else
    begin
      level_d_r <= fc.level_out;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= prescale_div;
    end
  end

  // a divisor change wins over a pending edge so a new ratio starts from a clean count
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pcnt_r <= '0;
    end
    else if (div_changed)
    begin
      pcnt_r <= '0; // RL13
    end
    else if (fire)
    begin
      pcnt_r <= '0; // RL13
    end
    else if (rise)
    begin
      pcnt_r <= pcnt_inc; // RL12
    end
  end

  // a single-cycle strobe; the camera side counts strobes, not levels
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      camera_trigger <= 1'b0;
    end
    else
    begin
      camera_trigger <= fire; // RL12
    end
  end
endmodule

//--- tb/trig_cond_sva.sv
`timescale 1ns/1ps
module trig_cond_sva
  import trig_cond_pkg::*;
#(
  parameter int unsigned NIN  = NUM_IN,
  parameter int unsigned NSTG = NUM_STAGES,
  parameter int unsigned NOUT = NUM_OUT
)
(
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic [NIN-1:0]             trig_in,
  input wire logic [NSTG-1:0][2:0]       stage_op,
  input wire logic [NSTG-1:0][SEL_W-1:0] stage_sel_a,
  input wire logic [NSTG-1:0][SEL_W-1:0] stage_sel_b,
  input wire logic [NOUT-1:0][SEL_W-1:0] out_sel,
  input wire logic                       camera_trigger,
  input wire logic [NOUT-1:0]            out_line
);
  logic [1:0] t1_r;
  logic [1:0] t2_r;
  logic [1:0] t3_r;
  logic [$bits(out_sel)+2*SEL_W+2:0] cfg;
  logic [$bits(out_sel)+2*SEL_W+2:0] cfg_q_r;
  logic [2:0] hold_r;
  logic       ok;
  assign cfg = {stage_op[0], out_sel, stage_sel_a[0], stage_sel_b[0]};
  // judged only once a changed setting has flushed the three-stage path;
  // out_line lags its settings by one edge, so the edge of a change is skipped as well
  assign ok = hold_r == 3'h4 && cfg == cfg_q_r && out_sel[0] == 3'h4 && out_sel[1] == 3'h0
    && stage_sel_a[0] == 3'h0 && stage_sel_b[0] == 3'h1;
  always_ff @(posedge clk)
  begin
    t1_r <= trig_in[1:0];
    t2_r <= t1_r;
    t3_r <= t2_r;
  end
  always_ff @(posedge clk)
  begin
    cfg_q_r <= cfg;
    if (!reset_n || cfg != cfg_q_r)
      hold_r <= 3'h0;
    else if (hold_r != 3'h4)
      hold_r <= hold_r + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_and; ok && stage_op[0] == OP_AND |-> out_line[0] == (t3_r[0] & t3_r[1]); endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_nand; ok && stage_op[0] == OP_NAND |-> out_line[0] == !(t3_r[0] & t3_r[1]); endproperty
  a_nand: assert property (p_nand) else $error("nand result wrong");
  property p_or; ok && stage_op[0] == OP_OR |-> out_line[0] == (t3_r[0] | t3_r[1]); endproperty
  a_or: assert property (p_or) else $error("or result wrong");
  property p_nor; ok && stage_op[0] == OP_NOR |-> out_line[0] == (!t3_r[0] & !t3_r[1]); endproperty
  a_nor: assert property (p_nor) else $error("nor result wrong");
  property p_nori; ok && stage_op[0] == OP_NOR_INV |-> out_line[0] == (t3_r[0] | t3_r[1]); endproperty
  a_nori: assert property (p_nori) else $error("inverted nor wrong");
  property p_route; ok |-> out_line[1] == t3_r[0]; endproperty
  a_route: assert property (p_route) else $error("routed line wrong");
  property p_rst; $rose(reset_n) |-> !camera_trigger && out_line == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_pulse; camera_trigger |=> !camera_trigger; endproperty
  a_pulse: assert property (p_pulse) else $error("trigger wider than one cycle");
endmodule
bind trigger_input_conditioner trig_cond_sva #(.NIN(NIN), .NSTG(NSTG), .NOUT(NOUT)) u_sva (.*);

//--- tb/trig_switch.sv
`timescale 1ns/1ps
module trig_switch
(
  input  wire logic       clk,
  output logic      [3:0] lines
);
  initial lines = 4'h0;
  // a contact held hi cycles, then released lo cycles; moves only at negedge
  task automatic pulse(input int b, input int hi, input int lo);
    @(negedge clk);
    lines[b] = 1'b1;
    repeat (hi) @(negedge clk);
    lines[b] = 1'b0;
    repeat (lo) @(negedge clk);
  endtask
  task automatic put(input logic [3:0] v);
    @(negedge clk);
    lines = v;
  endtask
endmodule

//--- tb/trigger_input_conditioner_tb_top.sv
`timescale 1ns/1ps
module trigger_input_conditioner_tb_top;
  import trig_cond_pkg::*;
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic [3:0]       trig_in;
  logic [1:0][2:0]  stage_op = '0;
  logic [1:0][2:0]  stage_sel_a = '0;
  logic [1:0][2:0]  stage_sel_b = {3'h0, 3'h1};
  logic [2:0]       trig_sel = 3'h2;
  logic [1:0][2:0]  out_sel = {3'h0, 3'h4};
  logic             filter_enable = 1'b0;
  logic [19:0]      glitch_filter_length = 20'h0;
  logic [3:0]       prescale_div = 4'h1;
  logic             camera_trigger;
  logic [1:0]       out_line;
  int               n_fail = 0;
  int               n_tests = 0;
  int               pulses = 0;
  int               cyc = 0;
  trigger_input_conditioner u_dut (.*);
  trig_switch sw (.clk(clk), .lines(trig_in));
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    pulses <= pulses + int'(camera_trigger === 1'b1);
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic comb_ops();
    // truth nibbles indexed by {b,a}: and, nand, or, nor, inverted nor
    logic [19:0] tt;
    tt = {4'he, 4'h1, 4'he, 4'h7, 4'h8};
    for (int op = 0; op < 5; op++)
    begin
      @(negedge clk);
      stage_op[0] = op[2:0];
      for (int v = 0; v < 4; v++)
      begin
        sw.put({2'h0, v[1:0]});
        repeat (6) @(negedge clk);
        chk(out_line, {v[0], tt[op*4+v]});
      end
    end
  endtask
  task automatic chain();
    int base;
    // stage1 nands stage0 with line 3 and drives both out_line[1] and the trigger path
    @(negedge clk);
    stage_op    = {3'h1, 3'h0};
    stage_sel_a = {3'h4, 3'h0};
    stage_sel_b = {3'h3, 3'h1};
    out_sel     = {3'h5, 3'h4};
    trig_sel    = 3'h5;
    sw.put(4'hb);
    repeat (6) @(negedge clk);
    chk(out_line, 2'h1);
    base = pulses;
    sw.put(4'h3);
    repeat (6) @(negedge clk);
    chk(out_line, 2'h3);
    chk(pulses - base, 1);
    @(negedge clk);
    out_sel  = {3'h0, 3'h4};
    trig_sel = 3'h2;
  endtask
  task automatic prescale(input logic [3:0] d, input int edges, input int e);
    int base;
    @(negedge clk);
    prescale_div = d;
    repeat (3) @(negedge clk);
    base = pulses;
    repeat (edges) sw.pulse(2, 3, 3);
    repeat (6) @(negedge clk);
    chk(pulses - base, e);
  endtask
  task automatic filter();
    int base;
    @(negedge clk);
    filter_enable = 1'b1;
    glitch_filter_length = 20'd40;
    prescale_div = 4'h1;
    repeat (3) @(negedge clk);
    base = pulses;
    // 40 units make a 30-cycle limit: 28 cycles are dropped, 32 pass
    sw.pulse(2, 28, 40);
    chk(pulses - base, 0);
    sw.pulse(2, 32, 40);
    chk(pulses - base, 1);
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    comb_ops();
    chain();
    prescale(4'h1, 3, 3);
    prescale(4'h3, 8, 2);
    prescale(4'h4, 2, 0);
    prescale(4'h0, 16, 1);
    filter();
    close_out();
  end
endmodule
